// ---- design/tlc_top.sv ----
// How it works
// (RULE_01) decimated pulse data goes out only when its enable is set, in its slot (reset 4).
// (RULE_02) supply readings go out only when enabled, in their six-bit slot (reset 6).
// (RULE_03) supply value is cut to 8 bits, or left-justified in 16 when the length bit is set.
// (RULE_04) temperature goes out only when enabled, in its slot (reset 7).
// (RULE_05) present gain reduction goes out only when enabled, in its slot (reset 8).
// (RULE_06) the limiter reduces gain only while its enable is set, and it resets off.
// (RULE_07) attack step is 0.25, 0.5, 1 or 2 dB by code, reset code 01.
// (RULE_08) attack interval is 5 us doubled per code up to 640 us, reset code 010.
// (RULE_09) release step is 0.25, 0.5, 1 or 2 dB by code, reset code 01.
// (RULE_10) release interval is 10 to 1500 ms per step by code, reset code 110.
// (RULE_11) a hold time of 0 to 1000 ms passes before release starts, reset code 6.
// (RULE_12) slot fields are six bits and the spare top bit is read/write, reset 0.
// (RULE_13) bits no enabled source owns are sent as zero or released, per the fill input.
// (RULE_14) software should order the slot numbers ascending across the sources.
// (RULE_15) a disabled source owns no slot, and settings take effect at a frame start; the attack and release registers act at once.
// (RULE_16) attack and release timing come from one tick derived from the clock.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module tlc_top (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_serial_bit_clock,
    input wire logic i_frame_sync,
    input wire logic i_fill_hiz,
    output logic o_serial_transmit_line,
    output logic o_serial_transmit_oe,
    input wire logic i_smp_valid,
    input wire logic [tlc_pkg::PDM_W-1:0] i_smp_pdm,
    input wire logic [tlc_pkg::VBAT_W-1:0] i_smp_vbat,
    input wire logic [tlc_pkg::TEMP_W-1:0] i_smp_temp,
    output logic o_smp_ready,
    input wire logic i_over_threshold,
    output logic [7:0] o_gain_reduction,
    output logic o_limiter_active
);
    import tlc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0] cfg_q [NUM_REGS];
    logic [7:0] rdata_q;

    wire addr_hit = (i_addr >= OFS_PDM_SLOT) && (i_addr <= OFS_RELEASE);
    wire [2:0] reg_idx = 3'(i_addr - OFS_PDM_SLOT);
    wire wr_hit = i_wr & addr_hit;
    wire [7:0] rd_val = addr_hit ? cfg_q[reg_idx] : 8'h00;

    // every bit is plain read/write, spare top bits included [RULE_12]
    for (genvar g = 0; g < NUM_REGS; g++)
    begin : g_cfg
        always_ff @(posedge i_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                cfg_q[g] <= CFG_RST[g];
            end
            else if (wr_hit && reg_idx == 3'(g))
            begin
                cfg_q[g] <= i_wdata;
            end
        end
    end

    // unmapped reads answer zero
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= i_rd ? rd_val : 8'h00;
        end
    end
    assign o_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // link pin sampling
    logic [2:0] bclk_sq;
    logic [2:0] fs_sq;
    logic bclk_lvl_q;
    logic fs_lvl_q;
    logic fs_prev_q;

    // a level counts only once the second and third stages agree
    wire bclk_lvl_d = (bclk_sq[1] == bclk_sq[2]) ? bclk_sq[2] : bclk_lvl_q;
    wire fs_lvl_d = (fs_sq[1] == fs_sq[2]) ? fs_sq[2] : fs_lvl_q;
    wire bclk_rise = bclk_lvl_d & ~bclk_lvl_q;
    wire bclk_fall = ~bclk_lvl_d & bclk_lvl_q;
    wire frame_start = bclk_rise & fs_lvl_q & ~fs_prev_q;

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bclk_sq <= 3'h0;
            fs_sq <= 3'h0;
            bclk_lvl_q <= 1'b0;
            fs_lvl_q <= 1'b0;
            fs_prev_q <= 1'b0;
        end
        else
        begin
            bclk_sq <= {bclk_sq[1:0], i_serial_bit_clock};
            fs_sq <= {fs_sq[1:0], i_frame_sync};
            bclk_lvl_q <= bclk_lvl_d;
            fs_lvl_q <= fs_lvl_d;
            fs_prev_q <= bclk_rise ? fs_lvl_q : fs_prev_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample buffer, one word taken per frame
    tlc_word_if #(.W(WORD_W)) smp_in ();
    tlc_word_if #(.W(WORD_W)) smp_out ();

    assign smp_in.valid = i_smp_valid;
    assign smp_in.data = {i_smp_pdm, i_smp_vbat, i_smp_temp};
    assign o_smp_ready = smp_in.ready;
    assign smp_out.ready = frame_start;

    tlc_pair_buf u_buf (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .fill(smp_in.snk),
        .drain(smp_out.src)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // frame snapshot and bit position
    logic [7:0] snap_q [NUM_SRC];
    logic [WORD_W-1:0] word_q;
    logic [7:0] gr_snap_q;
    logic [9:0] bit_cnt_q;
    logic [7:0] gr_q;

    // settings only move at a frame start so a frame is never torn [RULE_15]
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int k = 0; k < NUM_SRC; k++)
            begin
                snap_q[k] <= 8'h00;
            end
            word_q <= '0;
            gr_snap_q <= 8'h00;
            bit_cnt_q <= 10'h000;
        end
        else if (frame_start)
        begin
            for (int k = 0; k < NUM_SRC; k++)
            begin
                snap_q[k] <= cfg_q[k];
            end
            word_q <= smp_out.valid ? smp_out.data : '0;
            gr_snap_q <= gr_q;
            bit_cnt_q <= 10'h000;
        end
        else if (bclk_rise)
        begin
            bit_cnt_q <= 10'(bit_cnt_q + 10'h001);
        end
    end

    wire [5:0] slot_idx = bit_cnt_q[9:4];
    wire [3:0] bit_idx = bit_cnt_q[3:0];
    wire [PDM_W-1:0] w_pdm = word_q[WORD_W-1 -: PDM_W];
    wire [VBAT_W-1:0] w_vbat = word_q[TEMP_W +: VBAT_W];
    wire [TEMP_W-1:0] w_temp = word_q[TEMP_W-1:0];
    wire vbat_len16 = snap_q[1][SLEN_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // slot ownership
    logic [15:0] src_field [NUM_SRC];
    logic [NUM_SRC-1:0] src_len16;
    logic [NUM_SRC-1:0] src_hit;
    logic tx_bit;

    assign src_field[0] = w_pdm; // [RULE_01]
    assign src_field[1] = vbat_len16 ? {w_vbat, 4'h0} : {w_vbat[VBAT_W-1 -: 8], 8'h00}; // [RULE_03]
    assign src_field[2] = {w_temp, 8'h00}; // [RULE_04]
    assign src_field[3] = {gr_snap_q, 8'h00}; // [RULE_05]
    assign src_len16 = {1'b0, 1'b0, vbat_len16, 1'b1}; // [RULE_03]

    // a cleared enable owns nothing; short sources own only the top 8 bits
    for (genvar g = 0; g < NUM_SRC; g++)
    begin : g_src
        assign src_hit[g] = snap_q[g][TX_EN_BIT]
            && (slot_idx == snap_q[g][SLOT_LSB +: SLOT_W])
            && (src_len16[g] || !bit_idx[3]); // [RULE_01] [RULE_02] [RULE_04] [RULE_05] [RULE_15]
    end

    // overlapping slots: lower source index wins
    always_comb
    begin
        tx_bit = 1'b0;
        for (int k = NUM_SRC - 1; k >= 0; k--)
        begin
            if (src_hit[k])
            begin
                tx_bit = src_field[k][~bit_idx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // launch on the falling bit clock edge
    logic tx_q;
    logic oe_q;

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else if (bclk_fall)
        begin
            tx_q <= (|src_hit) & tx_bit;
            oe_q <= (|src_hit) | ~i_fill_hiz; // [RULE_13]
        end
    end
    assign o_serial_transmit_line = tx_q;
    assign o_serial_transmit_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////////////
    // shared time base: 5 us tick and 1 ms tick
    logic [8:0] tick_cnt_q;
    logic [7:0] ms_cnt_q;
    logic tick_q;
    logic ms_q;

    wire tick_wrap = tick_cnt_q == 9'(STEP_TICK_CYC - 1);
    wire ms_wrap = tick_q && (ms_cnt_q == 8'(MS_TICKS - 1));

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= 9'h000;
            ms_cnt_q <= 8'h00;
            tick_q <= 1'b0;
            ms_q <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_wrap ? 9'h000 : 9'(tick_cnt_q + 9'h001); // [RULE_16]
            tick_q <= tick_wrap;
            ms_cnt_q <= ms_wrap ? 8'h00 : (tick_q ? 8'(ms_cnt_q + 8'h01) : ms_cnt_q);
            ms_q <= ms_wrap; // [RULE_16]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // limiter gain reduction
    tlc_lim_st_t st_q;
    tlc_lim_st_t st_d;
    logic [7:0] gr_d;
    logic [7:0] atk_cnt_q;
    logic [7:0] atk_cnt_d;
    logic [10:0] tm_cnt_q;
    logic [10:0] tm_cnt_d;
    logic act_q;

    wire lim_on = cfg_q[4][LIM_ON_BIT];
    wire [2:0] atk_rt = cfg_q[4][ATK_RT_LSB +: 3];
    wire [1:0] atk_st = cfg_q[4][ATK_ST_LSB +: 2];
    wire [2:0] hold_code = cfg_q[5][HOLD_LSB +: 3];
    wire [2:0] rel_rt = cfg_q[5][REL_RT_LSB +: 3];
    wire [1:0] rel_st = cfg_q[5][REL_ST_LSB +: 2];
    wire [7:0] atk_limit = 8'((8'h01 << atk_rt) - 8'h01); // [RULE_08]
    wire [7:0] atk_step = 8'(8'h01 << atk_st); // [RULE_07]
    wire [7:0] rel_step = 8'(8'h01 << rel_st); // [RULE_09]
    wire [10:0] rel_limit = 11'(REL_MS[rel_rt] - 11'h001); // [RULE_10]
    wire [10:0] hold_limit = HOLD_MS[hold_code]; // [RULE_11]
    wire [8:0] gr_sum = {1'b0, gr_q} + {1'b0, atk_step};
    wire [7:0] gr_up = (gr_sum > {1'b0, GR_MAX_QDB}) ? GR_MAX_QDB : gr_sum[7:0];
    wire [7:0] gr_dn = (gr_q > rel_step) ? 8'(gr_q - rel_step) : 8'h00;
    wire atk_fire = (st_q == LIM_ATTACK) && i_over_threshold && tick_q && (atk_cnt_q == atk_limit);

    // ms tick phase is free running, so hold and release land within 1 ms early
    always_comb
    begin
        st_d = st_q;
        gr_d = gr_q;
        atk_cnt_d = atk_cnt_q;
        tm_cnt_d = tm_cnt_q;
        case (st_q)
            LIM_IDLE:
            begin
                if (i_over_threshold)
                begin
                    st_d = LIM_ATTACK;
                    atk_cnt_d = 8'h00;
                end
            end
            LIM_ATTACK:
            begin
                if (!i_over_threshold)
                begin
                    st_d = LIM_HOLD;
                    tm_cnt_d = 11'h000;
                end
                else if (tick_q)
                begin
                    atk_cnt_d = atk_fire ? 8'h00 : 8'(atk_cnt_q + 8'h01);
                    gr_d = atk_fire ? gr_up : gr_q; // [RULE_07] [RULE_08] [RULE_16]
                end
            end
            LIM_HOLD:
            begin
                if (i_over_threshold)
                begin
                    st_d = LIM_ATTACK;
                    atk_cnt_d = 8'h00;
                end
                else if (tm_cnt_q >= hold_limit)
                begin
                    st_d = LIM_RELEASE; // [RULE_11]
                    tm_cnt_d = 11'h000;
                end
                else if (ms_q)
                begin
                    tm_cnt_d = 11'(tm_cnt_q + 11'h001);
                end
            end
            LIM_RELEASE:
            begin
                if (i_over_threshold)
                begin
                    st_d = LIM_ATTACK;
                    atk_cnt_d = 8'h00;
                end
                else if (gr_q == 8'h00)
                begin
                    st_d = LIM_IDLE;
                end
                else if (ms_q)
                begin
                    tm_cnt_d = (tm_cnt_q == rel_limit) ? 11'h000 : 11'(tm_cnt_q + 11'h001);
                    gr_d = (tm_cnt_q == rel_limit) ? gr_dn : gr_q; // [RULE_09] [RULE_10]
                end
            end
            default:
            begin
                st_d = LIM_IDLE;
            end
        endcase
        if (!lim_on)
        begin
            st_d = LIM_IDLE; // [RULE_06]
            gr_d = 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= LIM_IDLE;
            gr_q <= 8'h00;
            atk_cnt_q <= 8'h00;
            tm_cnt_q <= 11'h000;
            act_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            gr_q <= gr_d;
            atk_cnt_q <= atk_cnt_d;
            tm_cnt_q <= tm_cnt_d;
            act_q <= st_d != LIM_IDLE;
        end
    end
    assign o_gain_reduction = gr_q;
    assign o_limiter_active = act_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    chk_gain_held_zero: assert property ( // [RULE_06]
        !lim_on |=> (o_gain_reduction == 8'h00) && !o_limiter_active)
        else $error("gain reduction while limiter off");
    chk_attack_step_add: assert property ( // [RULE_07]
        lim_on && atk_fire |=> o_gain_reduction == $past(gr_up))
        else $error("attack step not applied");
    chk_tick_period: assert property ( // [RULE_16]
        tick_q |-> ##[500:500] tick_q)
        else $error("5 us tick period wrong");
    chk_hold_before_rel: assert property ( // [RULE_11]
        (st_q == LIM_HOLD) && (st_d == LIM_RELEASE) |-> tm_cnt_q >= HOLD_MS[hold_code])
        else $error("release before hold expired");
    chk_idle_fill_out: assert property ( // [RULE_13]
        bclk_fall && (src_hit == '0) |=> !o_serial_transmit_line
            && (o_serial_transmit_oe == !$past(i_fill_hiz)))
        else $error("unowned bit not filled");
    chk_frame_snap_hold: assert property ( // [RULE_15]
        !frame_start |=> $stable(snap_q[0]) && $stable(snap_q[1]) && $stable(snap_q[2])
            && $stable(snap_q[3]))
        else $error("settings changed mid frame");
    chk_vbat_short_len: assert property ( // [RULE_03]
        bclk_fall && snap_q[1][TX_EN_BIT] && !vbat_len16 && bit_idx[3]
            && (slot_idx == snap_q[1][SLOT_LSB +: SLOT_W])
            && !src_hit[0] && !src_hit[2] && !src_hit[3]
            |=> !o_serial_transmit_line && (o_serial_transmit_oe == !$past(i_fill_hiz)))
        else $error("short supply field overran 8 bits");
    chk_spare_bit_rw: assert property ( // [RULE_12]
        i_wr && (i_addr == OFS_PDM_SLOT) ##1 !i_wr ##1 i_rd && !i_wr && (i_addr == OFS_PDM_SLOT)
        |=> o_rdata == $past(i_wdata, 3))
        else $error("slot register did not read back");
    chk_pdm_disabled: assert property ( // [RULE_01]
        !snap_q[0][TX_EN_BIT] |-> !src_hit[0])
        else $error("disabled source owns a slot");

endmodule : tlc_top

// ---- design/tlc_pkg.sv ----
package tlc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_TICK_NS = 5000;
    localparam int STEP_TICK_CYC = (STEP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_NS = 1000000;
    localparam int MS_TICKS = MS_NS / STEP_TICK_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // frame geometry
    localparam int SLOT_BITS = 16;
    localparam int NUM_SRC = 4;
    localparam int PDM_W = 16;
    localparam int VBAT_W = 12;
    localparam int TEMP_W = 8;
    localparam int WORD_W = PDM_W + VBAT_W + TEMP_W;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_PDM_SLOT = 8'h11;
    localparam logic [7:0] OFS_VBAT_SLOT = 8'h12;
    localparam logic [7:0] OFS_TEMP_SLOT = 8'h13;
    localparam logic [7:0] OFS_GAIN_SLOT = 8'h14;
    localparam logic [7:0] OFS_ATTACK = 8'h15;
    localparam logic [7:0] OFS_RELEASE = 8'h16;
    localparam int NUM_REGS = 6;

    // reset values, index order follows offsets
    localparam logic [7:0] RST_PDM_SLOT = 8'h04;
    localparam logic [7:0] RST_VBAT_SLOT = 8'h06;
    localparam logic [7:0] RST_TEMP_SLOT = 8'h07;
    localparam logic [7:0] RST_GAIN_SLOT = 8'h08;
    localparam logic [7:0] RST_ATTACK = 8'h14;
    localparam logic [7:0] RST_RELEASE = 8'h76;
    localparam logic [7:0] CFG_RST [NUM_REGS] = '{RST_PDM_SLOT, RST_VBAT_SLOT,
        RST_TEMP_SLOT, RST_GAIN_SLOT, RST_ATTACK, RST_RELEASE};

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int SLOT_LSB = 0;
    localparam int SLOT_W = 6;
    localparam int TX_EN_BIT = 6;
    localparam int SLEN_BIT = 7;
    localparam int LIM_ON_BIT = 0;
    localparam int ATK_RT_LSB = 1;
    localparam int ATK_ST_LSB = 4;
    localparam int HOLD_LSB = 0;
    localparam int REL_RT_LSB = 3;
    localparam int REL_ST_LSB = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // limiter tables, gain in quarter-dB units
    localparam logic [10:0] REL_MS [8] = '{11'd10, 11'd50, 11'd100, 11'd250,
        11'd500, 11'd750, 11'd1000, 11'd1500};
    localparam logic [10:0] HOLD_MS [8] = '{11'd0, 11'd10, 11'd25, 11'd50,
        11'd100, 11'd250, 11'd500, 11'd1000};
    localparam logic [7:0] GR_MAX_QDB = 8'h42;

    typedef enum {LIM_IDLE, LIM_ATTACK, LIM_HOLD, LIM_RELEASE} tlc_lim_st_t;

endpackage : tlc_pkg

// ---- design/tlc_word_if.sv ----
`timescale 1ns/10ps
interface tlc_word_if #(parameter int W = 36);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : tlc_word_if

// ---- design/tlc_pair_buf.sv ----
`timescale 1ns/10ps
module tlc_pair_buf (
    input wire logic i_clk,
    input wire logic i_rst_n,
    tlc_word_if.snk fill,
    tlc_word_if.src drain
);
    import tlc_pkg::*;

    logic [WORD_W-1:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic rdy_q;

    wire push = fill.valid & rdy_q;
    wire pop = drain.ready & (cnt_q != 2'h0);

    // ready is registered so the source sees a clean level
    assign cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    assign fill.ready = rdy_q;
    assign drain.valid = cnt_q != 2'h0;
    assign drain.data = mem_q[rd_ptr_q];

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
            rdy_q <= 1'b1;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != 2'h2;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= fill.data;
        end
    end

endmodule : tlc_pair_buf

// ---- tb/tlc_host_model.sv ----
`timescale 1ns/10ps
module tlc_host_model #(
    parameter int NBITS = 64
) (
    input wire logic i_go,
    input wire logic i_sdata,
    input wire logic i_oe,
    output logic o_bclk,
    output logic o_fsync,
    output logic [NBITS-1:0] o_bits,
    output logic [NBITS-1:0] o_oe,
    output logic o_busy
);
    // bit clock stands low between frames, so no stray edges reach the block
    initial
    begin
        o_bclk = 1'b0;
        o_fsync = 1'b0;
        o_busy = 1'b0;
        o_bits = '0;
        o_oe = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one low sync edge, one high sync edge, then sample data on rising edges
    always @(posedge i_go)
    begin
        o_busy = 1'b1;
        #3.3;
        for (int k = 0; k < NBITS + 2; k++)
        begin
            #62.5 o_bclk = 1'b1;
            if (k >= 2)
            begin
                o_bits[k-2] = i_sdata;
                o_oe[k-2] = i_oe;
            end
            #62.5 o_bclk = 1'b0;
            o_fsync = (k == 0);
        end
        o_busy = 1'b0;
    end
endmodule : tlc_host_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    import tlc_pkg::*;
    logic clk, arst_n, wr, rd, fill_hiz, smp_valid, over, go;
    logic [7:0] addr, wdata, temp;
    logic [15:0] pdm;
    logic [11:0] vbat;
    logic [63:0] exp_d, exp_oe;
    wire logic [7:0] rdata, gain;
    wire logic tx, oe, smp_ready, lim_act, bclk, fsync, busy;
    wire logic [63:0] cap_d, cap_oe;
    int fail_count = 0;
    int tests_run = 0;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    tlc_top dut (.i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_serial_bit_clock(bclk),
        .i_frame_sync(fsync), .i_fill_hiz(fill_hiz), .o_serial_transmit_line(tx),
        .o_serial_transmit_oe(oe), .i_smp_valid(smp_valid), .i_smp_pdm(pdm),
        .i_smp_vbat(vbat), .i_smp_temp(temp), .o_smp_ready(smp_ready),
        .i_over_threshold(over), .o_gain_reduction(gain), .o_limiter_active(lim_act));

    tlc_host_model #(.NBITS(64)) host (.i_go(go), .i_sdata(tx), .i_oe(oe), .o_bclk(bclk),
        .o_fsync(fsync), .o_bits(cap_d), .o_oe(cap_oe), .o_busy(busy));

    ////////////////////////////////////////////////////////////////////////////////
    task wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask : rd_chk

    // valid and data held until ready is seen at a falling edge, then valid dropped after the next rising edge
    task push(input logic [15:0] p, input logic [11:0] v, input logic [7:0] t);
        logic r;
        int n;
        @(posedge clk);
        smp_valid <= 1'b1;
        pdm <= p;
        vbat <= v;
        temp <= t;
        r = 1'b0;
        n = 0;
        while (!r)
        begin
            @(negedge clk);
            r = (smp_ready === 1'b1);
            @(posedge clk);
            n++;
            if (n > 50)
            begin
                fail_count++;
                wrap_up();
            end
        end
        smp_valid <= 1'b0;
    endtask : push

    task put(input int pos, input int n, input logic [15:0] v);
        for (int i = 0; i < n; i++)
        begin
            exp_d[pos+i] = v[15-i];
            exp_oe[pos+i] = 1'b1;
        end
    endtask : put

    task frame();
        int n;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (busy === 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000)
        begin
            fail_count++;
            wrap_up();
        end
        `CHK("tx_oe", exp_oe, cap_oe)
        `CHK("tx_data", exp_d & exp_oe, cap_d & exp_oe)
    endtask : frame

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {arst_n, wr, rd, fill_hiz, smp_valid, over, go} = '0;
        {addr, wdata, temp, pdm, vbat} = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        settle(4);
        `CHK("smp_ready", 1'b1, smp_ready)
        for (int i = 0; i < NUM_REGS; i++)
            rd_chk(OFS_PDM_SLOT + 8'(i), CFG_RST[i]);
        for (int i = 0; i < NUM_REGS; i++)
        begin
            wr_reg(OFS_PDM_SLOT + 8'(i), 8'hbf ^ 8'(i));
            rd_chk(OFS_PDM_SLOT + 8'(i), 8'hbf ^ 8'(i));
        end
        wr_reg(8'h17, 8'hff);
        rd_chk(8'h17, 8'h00);
        rd_chk(8'h10, 8'h00);
        // slots kept ascending across the sources
        wr_reg(OFS_PDM_SLOT, 8'h40);
        wr_reg(OFS_VBAT_SLOT, 8'hc1);
        wr_reg(OFS_TEMP_SLOT, 8'h42);
        wr_reg(OFS_GAIN_SLOT, 8'h03);
        wr_reg(OFS_ATTACK, 8'h14);
        push(16'ha5c3, 12'h9b7, 8'h6e);
        push(16'h1234, 12'h5a6, 8'hd9);
        settle(1);
        `CHK("smp_ready", 1'b0, smp_ready)
        exp_d = '0;
        exp_oe = '1;
        put(0, 16, 16'ha5c3);
        put(16, 16, {12'h9b7, 4'h0});
        put(32, 8, {8'h6e, 8'h00});
        frame();
        fill_hiz <= 1'b1;
        wr_reg(OFS_PDM_SLOT, 8'h00);
        wr_reg(OFS_VBAT_SLOT, 8'h41);
        wr_reg(OFS_GAIN_SLOT, 8'h43);
        exp_d = '0;
        exp_oe = '0;
        put(16, 8, {8'h5a, 8'h00});
        put(32, 8, {8'hd9, 8'h00});
        put(48, 8, 16'h0000);
        frame();
        over <= 1'b1;
        settle(2100);
        `CHK("gain", 8'h00, gain)
        wr_reg(OFS_ATTACK, 8'h15);
        settle(2100);
        `CHK("gain", 8'h02, gain)
        `CHK("active", 1'b1, lim_act)
        wr_reg(OFS_ATTACK, 8'h00);
        settle(2);
        `CHK("gain", 8'h00, gain)
        wr_reg(OFS_ATTACK, 8'h31);
        settle(5200);
        `CHK("gain", GR_MAX_QDB, gain)
        // buffer is empty now, so only the gain value carries data
        exp_d = '0;
        exp_oe = '0;
        put(16, 8, 16'h0000);
        put(32, 8, 16'h0000);
        put(48, 8, {GR_MAX_QDB, 8'h00});
        frame();
        // zero hold: release starts at once but its first step is ms away
        wr_reg(OFS_RELEASE, 8'h00);
        over <= 1'b0;
        settle(3);
        `CHK("gain", GR_MAX_QDB, gain)
        `CHK("active", 1'b1, lim_act)
        wrap_up();
    end
endmodule : tb
